// file: common/bbx_pkg.sv
package bbx_pkg;

  // ***********************************************
  // widths, counts, reset values and direction port addresses
  // ***********************************************
  localparam int FILE_DEPTH = 128;
  localparam int PC_WIDTH = 15;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [PC_WIDTH-1:0] PC_RESET = 15'h0000;
  localparam logic [6:0] DIR_PORT_A = 7'h05;
  localparam logic [6:0] DIR_PORT_B = 7'h06;
  localparam logic [6:0] DIR_PORT_C = 7'h07;
  localparam logic [1:0] SKIP_CYCLES = 2'h2;

  // ***********************************************
  // operation codes
  // ***********************************************
  typedef enum logic [3:0] {
    no_operation = 4'h0,
    bit_clear_op = 4'h1,
    bit_set_op = 4'h2,
    skip_if_bit_zero_op = 4'h3,
    skip_if_bit_one_op = 4'h4,
    relative_jump_op = 4'h5,
    accumulator_jump_op = 4'h6,
    direction_load_op = 4'h7,
    xor_immediate_op = 4'h8,
    xor_file_op = 4'h9
  } op_t;

  // decoded instruction from the fetch side
  typedef struct packed {
    op_t op;
    logic [6:0] file_addr;
    logic [2:0] bit_sel;
    logic dest_file;
    logic [8:0] literal;
  } instr_t;

endpackage : bbx_pkg

// file: hdl/bbx_alu.sv
`timescale 1ns/1ps
module bbx_alu
  import bbx_pkg::*;
(
  input wire logic [7:0] acc,
  input wire logic [7:0] operand,
  input wire logic [2:0] bit_sel,
  input wire op_t op,
  output logic [7:0] result,
  output logic bit_value,
  output logic zero
);
  // ***********************************************
  // combinational datapath
  // ***********************************************
  always_comb begin
    bit_value = operand[bit_sel];
    case (op)
      bit_clear_op: result = operand & ~(8'h01 << bit_sel);
      bit_set_op: result = operand | (8'h01 << bit_sel);
      xor_file_op: result = acc ^ operand;
      xor_immediate_op: result = acc ^ operand;
      default: result = operand;
    endcase
    zero = (result == 8'h00);
  end
endmodule : bbx_alu

// file: hdl/bit_branch_xor_executor.sv
`timescale 1ns/1ps
module bit_branch_xor_executor
  import bbx_pkg::*;
#(
  parameter int DEPTH = FILE_DEPTH
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire instr_t instr,
  input wire logic instr_valid,
  output logic [7:0] acc_reg,
  output logic zero_reg,
  output logic [PC_WIDTH-1:0] pc_reg,
  output logic [7:0] port_a_direction_reg,
  output logic [7:0] port_b_direction_reg,
  output logic [7:0] port_c_direction_reg,
  output logic flush_reg,
  output logic file_we_reg,
  output logic [6:0] file_addr_reg,
  output logic [7:0] file_wdata_reg
);
  // ***********************************************
  // reset release
  // ***********************************************
  logic rst_meta_reg;
  logic rst_n_reg;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ***********************************************
  // file register array and datapath
  // ***********************************************
  logic [7:0] file_mem [DEPTH];
  logic [7:0] result;
  logic bit_value;
  logic zero;
  logic [7:0] alu_operand;
  logic issue;
  assign issue = instr_valid && !flush_reg;
  assign alu_operand = (instr.op == xor_immediate_op) ? instr.literal[7:0] :
                       file_mem[instr.file_addr];

  bbx_alu u_alu (
    .acc(acc_reg),
    .operand(alu_operand),
    .bit_sel(instr.bit_sel),
    .op(instr.op),
    .result(result),
    .bit_value(bit_value),
    .zero(zero)
  );

  // file writes: bit ops and xor to file
  logic file_write;
  assign file_write = issue && ((instr.op == bit_clear_op) || (instr.op == bit_set_op) ||
                      (instr.op == xor_file_op && instr.dest_file));
  always_ff @(posedge clk_sys) begin
    if (file_write) begin
      file_mem[instr.file_addr] <= result;
    end
  end

  // write port mirror for observation
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      file_we_reg <= 1'b0;
      file_addr_reg <= 7'h00;
      file_wdata_reg <= 8'h00;
    end else begin
      file_we_reg <= file_write;
      file_addr_reg <= instr.file_addr;
      file_wdata_reg <= result;
    end
  end

  // ***********************************************
  // accumulator and zero flag
  // ***********************************************
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      acc_reg <= ACC_RESET;
      zero_reg <= 1'b0;
    end else if (issue) begin
      case (instr.op)
        xor_immediate_op: begin
          acc_reg <= result;
          zero_reg <= zero;
        end
        xor_file_op: begin
          if (!instr.dest_file) begin
            acc_reg <= result;
          end
          zero_reg <= zero;
        end
        default: begin
        end
      endcase
    end
  end

  // ***********************************************
  // direction registers
  // ***********************************************
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      port_a_direction_reg <= DIR_RESET;
      port_b_direction_reg <= DIR_RESET;
      port_c_direction_reg <= DIR_RESET;
    end else if (issue && instr.op == direction_load_op) begin
      if (instr.file_addr == DIR_PORT_A) port_a_direction_reg <= acc_reg;
      if (instr.file_addr == DIR_PORT_B) port_b_direction_reg <= acc_reg;
      if (instr.file_addr == DIR_PORT_C) port_c_direction_reg <= acc_reg;
    end
  end

  // ***********************************************
  // program counter and flush
  // ***********************************************
  logic [PC_WIDTH-1:0] pc_inc;
  logic [PC_WIDTH-1:0] lit_ext;
  logic take_skip;
  assign pc_inc = pc_reg + 15'h0001;
  assign lit_ext = {{(PC_WIDTH-9){instr.literal[8]}}, instr.literal};
  assign take_skip = issue && (((instr.op == skip_if_bit_zero_op) && !bit_value) ||
                     ((instr.op == skip_if_bit_one_op) && bit_value));

  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pc_reg <= PC_RESET;
      flush_reg <= 1'b0;
    end else if (instr_valid) begin
      flush_reg <= 1'b0;
      pc_reg <= pc_inc;
      if (issue) begin
        case (instr.op)
          relative_jump_op: begin
            pc_reg <= pc_inc + lit_ext;
            flush_reg <= 1'b1;
          end
          accumulator_jump_op: begin
            pc_reg <= pc_inc + {7'h00, acc_reg};
            flush_reg <= 1'b1;
          end
          default: flush_reg <= take_skip;
        endcase
      end
    end
  end

  // ***********************************************
  // checks
  // ***********************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n_reg);

  skip_zero_flush_a: assert property (instr_valid && !flush_reg &&
    instr.op == skip_if_bit_zero_op && !bit_value |=> flush_reg)
    else $error("skip on zero bit did not discard");
  skip_one_flush_a: assert property (instr_valid && !flush_reg &&
    instr.op == skip_if_bit_one_op && bit_value |=> flush_reg)
    else $error("skip on one bit did not discard");
  rel_jump_target_a: assert property (issue &&
    instr.op == relative_jump_op |=>
    pc_reg == $past(pc_reg) + 15'h0001 + $past(lit_ext))
    else $error("relative jump target wrong");
  acc_jump_target_a: assert property (issue &&
    instr.op == accumulator_jump_op |=>
    pc_reg == $past(pc_reg) + 15'h0001 + {7'h00, $past(acc_reg)})
    else $error("accumulator jump target wrong");
  flag_keep_bits_a: assert property (issue && instr.op inside {
    bit_clear_op, bit_set_op, skip_if_bit_zero_op, skip_if_bit_one_op,
    relative_jump_op, accumulator_jump_op, direction_load_op} |=> $stable(zero_reg))
    else $error("zero flag changed by non-xor op");
  xor_imm_acc_a: assert property (issue &&
    instr.op == xor_immediate_op |=>
    acc_reg == ($past(acc_reg) ^ $past(instr.literal[7:0])))
    else $error("immediate xor result wrong");
  zero_flag_value_a: assert property (issue &&
    instr.op == xor_immediate_op |=>
    zero_reg == (acc_reg == 8'h00))
    else $error("zero flag wrong");
  xor_file_dest_a: assert property (issue &&
    instr.op == xor_file_op && instr.dest_file |=>
    file_we_reg && $stable(acc_reg))
    else $error("file xor destination wrong");
  bit_clear_write_a: assert property (issue &&
    instr.op == bit_clear_op |=>
    file_we_reg && !file_wdata_reg[$past(instr.bit_sel)])
    else $error("bit clear wrong");
  bit_set_write_a: assert property (issue &&
    instr.op == bit_set_op |=>
    file_we_reg && file_wdata_reg[$past(instr.bit_sel)])
    else $error("bit set wrong");
  dir_load_b_a: assert property (issue &&
    instr.op == direction_load_op && instr.file_addr == DIR_PORT_B |=>
    port_b_direction_reg == $past(acc_reg))
    else $error("direction load wrong");

  skip_taken_c: cover property (take_skip ##1 flush_reg);
  rel_jump_c: cover property (issue && instr.op == relative_jump_op);
  xor_zero_c: cover property (issue && instr.op == xor_file_op && zero);
  dir_load_c: cover property (issue && instr.op == direction_load_op);
endmodule : bit_branch_xor_executor

// file: verif/tb_bit_branch_xor_executor.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module tb_bit_branch_xor_executor
  import bbx_pkg::*;
;
  // ***********************************************
  // design ports and reference model state
  // ***********************************************
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  instr_t instr = '0;
  logic instr_valid = 1'b0;
  logic [7:0] acc_reg, port_a_direction_reg, port_b_direction_reg, port_c_direction_reg;
  logic [7:0] file_wdata_reg, m_acc, m_wd, f, r;
  logic [6:0] file_addr_reg, m_wa;
  logic [PC_WIDTH-1:0] pc_reg;
  logic zero_reg, flush_reg, file_we_reg, m_z, m_fl, m_we;
  logic [7:0] m_dir [3];
  logic [7:0] m_mem [128];
  int m_pc, n_mismatch, check_count;
  bit live;

  bit_branch_xor_executor u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .instr(instr),
    .instr_valid(instr_valid), .acc_reg(acc_reg), .zero_reg(zero_reg), .pc_reg(pc_reg),
    .port_a_direction_reg(port_a_direction_reg), .port_b_direction_reg(port_b_direction_reg),
    .port_c_direction_reg(port_c_direction_reg), .flush_reg(flush_reg),
    .file_we_reg(file_we_reg), .file_addr_reg(file_addr_reg), .file_wdata_reg(file_wdata_reg));

  // 10 MHz clock
  always #50 clk_sys = ~clk_sys;

  function automatic instr_t mk(op_t o, logic [6:0] a, logic [2:0] b, logic d, logic [8:0] k);
    return '{o, a, b, d, k};
  endfunction : mk

  // ***********************************************
  // drive one cycle and step the model at its edge
  // ***********************************************
  task automatic apply(input instr_t i, input logic v);
    instr <= i;
    instr_valid <= v;
    @(posedge clk_sys);
    m_we = 1'b0;
    if (!v) return;
    m_pc = (m_pc + 1) & 32'h7FFF;
    if (m_fl) begin
      m_fl = 1'b0; // discarded slot acts as a no-op
      return;
    end
    f = m_mem[i.file_addr];
    r = m_acc ^ f;
    case (i.op)
      bit_clear_op, bit_set_op: begin
        f[i.bit_sel] = (i.op == bit_set_op);
        r = f;
        m_we = 1'b1;
      end
      skip_if_bit_zero_op: m_fl = (f[i.bit_sel] === 1'b0);
      skip_if_bit_one_op: m_fl = (f[i.bit_sel] === 1'b1);
      relative_jump_op: begin
        m_pc = (m_pc + {{23{i.literal[8]}}, i.literal}) & 32'h7FFF;
        m_fl = 1'b1;
      end
      accumulator_jump_op: begin
        m_pc = (m_pc + m_acc) & 32'h7FFF;
        m_fl = 1'b1;
      end
      direction_load_op: if (i.file_addr inside {[5:7]}) m_dir[i.file_addr - 5] = m_acc;
      xor_immediate_op: begin
        m_acc = m_acc ^ i.literal[7:0];
        m_z = (m_acc == 8'h00);
      end
      xor_file_op: begin
        m_z = (r == 8'h00);
        if (i.dest_file) m_we = 1'b1;
        else m_acc = r;
      end
      default: ;
    endcase
    if (m_we) begin
      m_mem[i.file_addr] = r;
      m_wa = i.file_addr;
      m_wd = r;
    end
  endtask : apply

  // compare every settled output with the model, write address and data only when the model writes
  always @(negedge clk_sys) begin
    if (live) begin
      `CHK(acc_reg, m_acc)
      `CHK(zero_reg, m_z)
      `CHK(pc_reg, m_pc[PC_WIDTH-1:0])
      `CHK(port_a_direction_reg, m_dir[0])
      `CHK(port_b_direction_reg, m_dir[1])
      `CHK(port_c_direction_reg, m_dir[2])
      `CHK(flush_reg, m_fl)
      `CHK(file_we_reg, m_we)
      if (m_we) `CHK({file_addr_reg, file_wdata_reg}, {m_wa, m_wd})
    end
  end

  task automatic complete_run();
    $display("mismatches %0d of %0d comparisons", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // ***********************************************
  // main sequence
  // ***********************************************
  initial begin
    m_acc = ACC_RESET;
    m_z = 1'b0;
    m_fl = 1'b0;
    m_we = 1'b0;
    m_pc = 0;
    m_dir = '{DIR_RESET, DIR_RESET, DIR_RESET};
    void'($urandom(32'h4a2f));
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    live = 1'b1;
    // clear files 0..7 bit by bit so later reads are known
    for (int a = 0; a < 8; a++) begin
      for (int b = 0; b < 8; b++) apply(mk(bit_clear_op, 7'(a), 3'(b), 1'b0, 9'h000), 1'b1);
    end
    apply(mk(xor_immediate_op, 7'h00, 3'h0, 1'b0, 9'h0A5), 1'b1);
    for (int a = 4; a < 8; a++) apply(mk(direction_load_op, 7'(a), 3'h0, 1'b0, 9'h000), 1'b1);
    apply(mk(relative_jump_op, 7'h00, 3'h0, 1'b0, 9'h100), 1'b1);
    apply(mk(xor_immediate_op, 7'h00, 3'h0, 1'b0, 9'h0FF), 1'b1);
    apply(mk(relative_jump_op, 7'h00, 3'h0, 1'b0, 9'h0FF), 1'b1);
    apply(mk(accumulator_jump_op, 7'h00, 3'h0, 1'b0, 9'h000), 1'b1);
    // first one sits in the discarded slot, this one really jumps
    apply(mk(accumulator_jump_op, 7'h00, 3'h0, 1'b0, 9'h000), 1'b1);
    apply(mk(bit_set_op, 7'h01, 3'h7, 1'b0, 9'h000), 1'b1);
    apply(mk(skip_if_bit_one_op, 7'h01, 3'h7, 1'b0, 9'h000), 1'b1);
    apply(mk(skip_if_bit_zero_op, 7'h01, 3'h7, 1'b0, 9'h000), 1'b1);
    apply(mk(skip_if_bit_zero_op, 7'h01, 3'h0, 1'b0, 9'h000), 1'b1);
    apply(mk(xor_file_op, 7'h01, 3'h0, 1'b1, 9'h000), 1'b1);
    apply(mk(xor_immediate_op, 7'h00, 3'h0, 1'b0, {1'b0, m_acc}), 1'b1);
    // random mix with idle gaps
    repeat (300) begin
      apply(mk(op_t'($urandom_range(9, 0)), 7'($urandom_range(7, 0)), 3'($urandom),
        1'($urandom), 9'($urandom)), 1'($urandom_range(4, 0) != 0));
    end
    apply(mk(no_operation, 7'h00, 3'h0, 1'b0, 9'h000), 1'b0);
    @(posedge clk_sys);
    complete_run();
  end

  // hang guard, far beyond the expected run length
  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end
endmodule : tb_bit_branch_xor_executor
